// File: shared/sbm_pkg.sv
// Package of offsets, fields, timing constants and shared types for the serial byte master
package sbm_pkg;

   // ---------------------------------------------------------------
   // Register offsets on the byte-wide configuration port
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_DATA  = 8'hb0;  // serial_byte_data
   localparam logic [7:0] OFS_INDEX = 8'hb1;  // serial_byte_index
   localparam logic [7:0] OFS_TADDR = 8'hb2;  // serial_target_address
   localparam logic [7:0] OFS_CTRL  = 8'hb3;  // Control/status

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int         TADDR_DIR_BIT  = 0;      // direction_bit
   localparam int         CTRL_PROT_BIT  = 7;      // short_protocol_select
   localparam int         CTRL_BUSY_BIT  = 5;      // request_in_progress_flag
   localparam int         CTRL_TEST_BIT  = 2;      // fast_clock_test_bit
   localparam int         CTRL_ERR_BIT   = 1;      // Request error, write 1 to clear
   localparam logic [7:0] RST_BYTE       = 8'h00;  // Reset value of every register
   localparam logic       RST_BIT        = 1'b0;   // Reset value of every flag

   // ---------------------------------------------------------------
   // Timing: link clock and serial clock quarter periods
   // ---------------------------------------------------------------
   localparam int         LINK_CLK_PERIOD_NS = 32;    // Link clock period
   localparam int         SCL_NORMAL_KHZ     = 100;   // Normal serial clock rate
   localparam int         SCL_TEST_KHZ       = 1000;  // Raised rate in test mode
   localparam int         QUARTER_NORMAL_NS  = 1000000 / (SCL_NORMAL_KHZ * 4);
   localparam int         QUARTER_TEST_NS    = 1000000 / (SCL_TEST_KHZ * 4);
   // Longest time per quarter, so round down
   localparam logic [7:0] Q_NORM_CYC = 8'(QUARTER_NORMAL_NS / LINK_CLK_PERIOD_NS);
   localparam logic [7:0] Q_TEST_CYC = 8'(QUARTER_TEST_NS / LINK_CLK_PERIOD_NS);
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;    // Data bits before the acknowledge slot

   // ---------------------------------------------------------------
   // Link sequencer items and states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      I_START  = 3'b000,
      I_ADDRW  = 3'b001,
      I_INDEX  = 3'b010,
      I_DATA   = 3'b011,
      I_RSTART = 3'b100,
      I_ADDRR  = 3'b101,
      I_RECV   = 3'b110,
      I_STOP   = 3'b111
   } sbm_item_t;

   typedef enum logic [1:0] {
      L_IDLE  = 2'b00,
      L_START = 2'b01,
      L_BYTE  = 2'b10,
      L_STOP  = 2'b11
   } sbm_lstate_t;

endpackage

// File: design/sbm_sync.sv
// Two-flop synchroniser for levels and toggles entering a clock domain
`timescale 1ns/1ps

module sbm_sync
   import sbm_pkg::*;
#(
   parameter int W = 1   // Number of independent bits
)(
   input  wire logic         clock,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] meta;   // First stage, read only by the second
      logic [W-1:0] sync;   // Safe to use
   } sbm_sync_st_t;

   sbm_sync_st_t s_r;    // Registered state
   sbm_sync_st_t s_nxt;  // Next state

   // Shift one stage per edge
   always_comb begin
      s_nxt      = s_r;
      s_nxt.meta = d;
      s_nxt.sync = s_r.meta;
   end

   // Register; the reset value is a constant
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.sync;

endmodule // sbm_sync

// File: design/sbm_master.sv
// Serial two-wire bus master for single-byte reads and writes
//
// Operation
// - Data register sends write byte, keeps read byte
// - Index register gives byte address sent
// - Address bits 7..1 give the target address
// - Address bit 0: 0 write, 1 read
// - Registers clear only on global reset
// - Address write launches access, sets busy flag
// - Missing acknowledge sets sticky error, write-1 clears
// - Short protocol omits the byte address
// - Serial clock near 100 kHz, test raises it
`timescale 1ns/1ps

module sbm_master
   import sbm_pkg::*;
(
   input  wire logic       clock,       // Register side clock, 100 MHz
   input  wire logic       reset_n,     // global_reset_n, asynchronous
   input  wire logic [7:0] cfg_addr,    // Configuration byte offset
   input  wire logic       cfg_wr,      // Write strobe, one cycle
   input  wire logic       cfg_rd,      // Read strobe, one cycle
   input  wire logic [7:0] cfg_wdata,   // Write data
   output logic      [7:0] cfg_rdata,   // Read data, valid the cycle after cfg_rd
   input  wire logic       link_clock,  // Bit engine clock
   input  wire logic       scl_i,       // Serial clock wire level
   output logic            scl_o,       // Serial clock drive level, always low
   output logic            scl_oe,      // High while pulling the clock low
   input  wire logic       sda_i,       // Serial data wire level
   output logic            sda_o,       // Serial data drive level, always low
   output logic            sda_oe       // High while pulling data low
);

   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   // Register side
   typedef struct packed {
      logic [7:0] byte_data_field;           // Data register
      logic [7:0] byte_address_field;        // Index register
      logic [7:0] target_reg;                // {target_address_field, direction_bit}
      logic       short_protocol_select;     // Send/receive byte protocol
      logic       fast_clock_test_bit;       // Raised serial clock
      logic       request_in_progress_flag;  // Busy
      logic       req_err;                   // Sticky request error
      logic       req_tgl;                   // Request event toward the link
      logic       done_seen;                 // Last completion taken
      logic [7:0] rdata;                     // Read data output
   } sbm_hst_t;

   // Link side
   typedef struct packed {
      sbm_lstate_t st;        // Engine state
      logic [1:0]  ph;        // Quarter of the current bit
      logic [7:0]  q;         // Cycles left in the quarter
      logic [3:0]  bitn;      // Bit within the byte, 8 is the acknowledge slot
      logic [2:0]  step;      // Position in the item sequence
      logic        rd;        // Captured direction
      logic        shrt;      // Captured short protocol
      logic        fast;      // Captured test rate
      logic        tx;        // Byte is sent, not received
      logic [7:0]  sh;        // Shift register, holds the read byte at the end
      logic        err;       // Acknowledge missing
      logic        req_seen;  // Last request taken
      logic        done_tgl;  // Completion event toward the register side
      logic        scl_oe;    // Clock pull-down
      logic        sda_oe;    // Data pull-down
      logic        lvl;       // Open-drain level, stays low
   } sbm_lnk_t;

   sbm_hst_t h_r;      // Register side state
   sbm_hst_t h_nxt;    // Its next value
   sbm_lnk_t l_r;      // Link side state
   sbm_lnk_t l_nxt;    // Its next value
   logic     done_s;   // Completion toggle, synchronised
   logic     req_s;    // Request toggle, synchronised
   logic     scl_s;    // Clock wire, synchronised
   logic     sda_s;    // Data wire, synchronised
   logic     done_evt; // Completion seen this cycle
   logic     wr_ok;    // Write that may change configuration
   logic     tick;     // Quarter ends this cycle
   logic     dbit;     // Level wanted on the data wire
   logic [7:0] qlen;   // Quarter length in use

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Bus item at a sequence step; steps past the end stay at stop
   function automatic sbm_item_t item_of(input logic [2:0] step, input logic rd, input logic shrt);
      logic [23:0] tbl;
      tbl = '0;
      unique case ({rd, shrt})
         2'b00: tbl = {I_STOP, I_STOP, I_STOP, I_STOP, I_DATA, I_INDEX, I_ADDRW, I_START};
         2'b01: tbl = {I_STOP, I_STOP, I_STOP, I_STOP, I_STOP, I_DATA, I_ADDRW, I_START};
         2'b10: tbl = {I_STOP, I_STOP, I_RECV, I_ADDRR, I_RSTART, I_INDEX, I_ADDRW, I_START};
         2'b11: tbl = {I_STOP, I_STOP, I_STOP, I_STOP, I_STOP, I_RECV, I_ADDRR, I_START};
      endcase
      return sbm_item_t'(tbl[3*step +: 3]);
   endfunction

   // Enter one item: set state and load the byte it carries
   function automatic sbm_lnk_t load_item(input sbm_lnk_t s, input sbm_item_t it);
      sbm_lnk_t n;
      n      = s;
      n.ph   = 2'd0;
      n.bitn = 4'h0;
      n.tx   = 1'b1;
      n.st   = L_BYTE;  // Every item but start and stop carries a byte
      unique case (it)
         I_START, I_RSTART: n.st = L_START;
         I_STOP:            n.st = L_STOP;
         I_ADDRW:           n.sh = {h_r.target_reg[7:1], 1'b0};
         I_ADDRR:           n.sh = {h_r.target_reg[7:1], 1'b1};
         I_INDEX:           n.sh = h_r.byte_address_field;
         I_DATA:            n.sh = h_r.byte_data_field;
         I_RECV:            n.tx = 1'b0;  // All eight bits shift in, so the old byte needs no clear
      endcase
      return n;
   endfunction

   // Read multiplexer; unmapped offsets read zero
   function automatic logic [7:0] read_mux(input sbm_hst_t s, input logic [7:0] a);
      logic [7:0] v;
      v = RST_BYTE;
      unique case (a)
         OFS_DATA:  v = s.byte_data_field;
         OFS_INDEX: v = s.byte_address_field;
         OFS_TADDR: v = s.target_reg;
         OFS_CTRL: begin
            v[CTRL_PROT_BIT] = s.short_protocol_select;
            v[CTRL_BUSY_BIT] = s.request_in_progress_flag;
            v[CTRL_TEST_BIT] = s.fast_clock_test_bit;
            v[CTRL_ERR_BIT]  = s.req_err;
         end
         default: v = RST_BYTE;
      endcase
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Crossings
   // ---------------------------------------------------------------
   // Completion returns as a toggle; the read byte and error stay put until the next request
   sbm_sync #(.W(1)) u_done_sync (.clock(clock), .reset_n(reset_n), .d(l_r.done_tgl), .q(done_s));

   // Request toggle and both wires into the link domain
   sbm_sync #(.W(3)) u_link_sync (.clock(link_clock), .reset_n(reset_n), .d({h_r.req_tgl, scl_i, sda_i}),
      .q({req_s, scl_s, sda_s}));

   // ---------------------------------------------------------------
   // Register side
   // ---------------------------------------------------------------
   // Configuration is frozen while busy so the link reads stable words
   always_comb begin
      h_nxt    = h_r;
      done_evt = (done_s != h_r.done_seen);
      wr_ok    = cfg_wr && !h_r.request_in_progress_flag;
      if (wr_ok && cfg_addr == OFS_DATA) h_nxt.byte_data_field = cfg_wdata;
      if (wr_ok && cfg_addr == OFS_INDEX) h_nxt.byte_address_field = cfg_wdata;
      // Address write launches the access
      if (wr_ok && cfg_addr == OFS_TADDR) begin
         h_nxt.target_reg               = cfg_wdata;
         h_nxt.request_in_progress_flag = 1'b1;
         h_nxt.req_tgl                  = ~h_r.req_tgl;
      end
      if (cfg_wr && cfg_addr == OFS_CTRL) begin
         if (!h_r.request_in_progress_flag) begin
            h_nxt.short_protocol_select = cfg_wdata[CTRL_PROT_BIT];
            h_nxt.fast_clock_test_bit   = cfg_wdata[CTRL_TEST_BIT];
         end
         // Write one clears
         if (cfg_wdata[CTRL_ERR_BIT]) h_nxt.req_err = 1'b0;
      end
      // Completion comes after the clear, so a new error wins
      if (done_evt) begin
         h_nxt.done_seen                = done_s;
         h_nxt.request_in_progress_flag = 1'b0;
         if (h_r.target_reg[TADDR_DIR_BIT]) h_nxt.byte_data_field = l_r.sh;
         if (l_r.err) h_nxt.req_err = 1'b1;
      end
      // Registered read data
      if (cfg_rd) h_nxt.rdata = read_mux(h_r, cfg_addr);
   end

   // Only the global reset clears the registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         h_r <= '0;
      end else begin
         h_r <= h_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Link side bit engine
   // ---------------------------------------------------------------
   // Each bit has four quarters: set data, release clock, sample, pull clock
   always_comb begin
      l_nxt = l_r;
      tick  = (l_r.q == 8'h00);
      qlen  = l_r.fast ? Q_TEST_CYC : Q_NORM_CYC;
      dbit  = (l_r.tx && l_r.bitn < BITS_PER_BYTE) ? l_r.sh[7] : 1'b1;
      // Wire drive follows the current item and quarter
      unique case (l_r.st)
         L_IDLE: begin
            l_nxt.scl_oe = 1'b0;
            l_nxt.sda_oe = 1'b0;
         end
         // Data falls while clock is high: start or repeated start
         L_START: begin
            l_nxt.scl_oe = (l_r.ph == 2'd0) ? l_r.scl_oe : (l_r.ph == 2'd3);
            l_nxt.sda_oe = (l_r.ph >= 2'd2);
         end
         L_BYTE: begin
            l_nxt.scl_oe = (l_r.ph == 2'd0) || (l_r.ph == 2'd3);
            l_nxt.sda_oe = ~dbit;
         end
         // Data rises while clock is high: stop
         L_STOP: begin
            l_nxt.scl_oe = (l_r.ph == 2'd0);
            l_nxt.sda_oe = (l_r.ph <= 2'd1);
         end
      endcase
      if (l_r.st == L_IDLE) begin
         // New request: capture mode, the words stay frozen until done
         if (req_s != l_r.req_seen) begin
            l_nxt.req_seen = req_s;
            l_nxt.rd       = h_r.target_reg[TADDR_DIR_BIT];
            l_nxt.shrt     = h_r.short_protocol_select;
            l_nxt.fast     = h_r.fast_clock_test_bit;
            l_nxt.err      = 1'b0;
            l_nxt.step     = 3'd0;
            l_nxt.q        = (h_r.fast_clock_test_bit ? Q_TEST_CYC : Q_NORM_CYC) - 8'h01;
            l_nxt          = load_item(l_nxt, I_START);
         end
      end else if (!tick) begin
         l_nxt.q = l_r.q - 8'h01;
      end else if (l_r.ph == 2'd1 && !scl_s) begin
         // A target holding the clock low stretches the high quarter
         l_nxt.q = 8'h00;
      end else begin
         l_nxt.ph = l_r.ph + 2'd1;
         l_nxt.q  = qlen - 8'h01;
         if (l_r.st == L_BYTE && l_r.ph == 2'd2) begin
            if (l_r.bitn < BITS_PER_BYTE && !l_r.tx) l_nxt.sh = {l_r.sh[6:0], sda_s};
            // Released acknowledge slot means no target answered
            if (l_r.bitn == BITS_PER_BYTE && l_r.tx && sda_s) l_nxt.err = 1'b1;
         end
         if (l_r.st == L_BYTE && l_r.ph == 2'd3) begin
            if (l_r.tx && l_r.bitn < BITS_PER_BYTE) l_nxt.sh = {l_r.sh[6:0], 1'b0};
            l_nxt.bitn = l_r.bitn + 4'h1;
         end
         // Item ends: stop early on error, else take the next item
         if (l_r.ph == 2'd3) begin
            if (l_r.st == L_STOP) begin
               l_nxt.st       = L_IDLE;
               l_nxt.done_tgl = ~l_r.done_tgl;
            end else if (l_r.st == L_START || l_r.bitn == BITS_PER_BYTE) begin
               l_nxt.step = l_r.step + 3'd1;
               if (l_nxt.err) begin
                  l_nxt = load_item(l_nxt, I_STOP);
               end else begin
                  l_nxt = load_item(l_nxt, item_of(l_r.step + 3'd1, l_r.rd, l_r.shrt));
               end
            end
         end
      end
   end

   // Link state register
   always_ff @(posedge link_clock or negedge reset_n) begin
      if (!reset_n) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   // Outputs, all from flops
   assign cfg_rdata = h_r.rdata;
   assign scl_oe    = l_r.scl_oe;
   assign sda_oe    = l_r.sda_oe;
   assign scl_o     = l_r.lvl;
   assign sda_o     = l_r.lvl;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   busy_launch_a: assert property (@(posedge clock) disable iff (!reset_n)
      cfg_wr && cfg_addr == OFS_TADDR && !h_r.request_in_progress_flag
      |=> h_r.request_in_progress_flag && h_r.req_tgl != $past(h_r.req_tgl))
      else $error("busy flag not set by address write");
   cfg_frozen_a: assert property (@(posedge clock) disable iff (!reset_n)
      h_r.request_in_progress_flag |=> $stable(h_r.byte_address_field) && $stable(h_r.target_reg))
      else $error("configuration changed while busy");
   read_capture_a: assert property (@(posedge clock) disable iff (!reset_n)
      done_evt && h_r.target_reg[TADDR_DIR_BIT]
      |=> h_r.byte_data_field == $past(l_r.sh) && !h_r.request_in_progress_flag)
      else $error("read byte not captured at completion");
   err_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
      cfg_wr && cfg_addr == OFS_CTRL && cfg_wdata[CTRL_ERR_BIT] && !(done_evt && l_r.err) |=> !h_r.req_err)
      else $error("error flag not cleared by write one");
   err_set_a: assert property (@(posedge clock) disable iff (!reset_n)
      done_evt && l_r.err |=> h_r.req_err) else $error("error flag lost at completion");
   start_cond_a: assert property (@(posedge link_clock) disable iff (!reset_n)
      $rose(l_r.sda_oe) && !l_r.scl_oe |-> $past(l_r.st) == L_START)
      else $error("data fell with clock high outside a start");
   stop_cond_a: assert property (@(posedge link_clock) disable iff (!reset_n)
      $fell(l_r.sda_oe) && !l_r.scl_oe |-> $past(l_r.st) == L_STOP)
      else $error("data rose with clock high outside a stop");
   addr_sent_a: assert property (@(posedge link_clock) disable iff (!reset_n)
      l_r.st == L_BYTE && l_r.step == 3'd1 && l_r.bitn == 4'h0 && l_r.ph == 2'd0
      |-> l_r.sh == {h_r.target_reg[7:1], l_r.rd && l_r.shrt})
      else $error("wrong address byte loaded");
   index_sent_a: assert property (@(posedge link_clock) disable iff (!reset_n)
      l_r.st == L_BYTE && !l_r.shrt && l_r.step == 3'd2 && l_r.bitn == 4'h0 && l_r.ph == 2'd0
      |-> l_r.sh == h_r.byte_address_field)
      else $error("index byte not sent after address");
   short_proto_a: assert property (@(posedge link_clock) disable iff (!reset_n)
      l_r.st == L_BYTE && l_r.shrt && !l_r.rd && l_r.step == 3'd2 && l_r.bitn == 4'h0 && l_r.ph == 2'd0
      |-> l_r.sh == h_r.byte_data_field)
      else $error("short protocol sent the index byte");
   nack_err_a: assert property (@(posedge link_clock) disable iff (!reset_n)
      l_r.st == L_BYTE && l_r.tx && l_r.bitn == BITS_PER_BYTE && l_r.ph == 2'd2 && tick && sda_s
      |=> l_r.err ##[1:1000] l_r.st == L_STOP)
      else $error("missing acknowledge not flagged");
   scl_low_a: assert property (@(posedge link_clock) disable iff (!reset_n)
      $rose(l_r.scl_oe) && !l_r.fast |-> ##1 l_r.scl_oe [*8]) else $error("serial clock low phase too short");

endmodule // sbm_master

// File: dv/sbm_target.sv
// Behavioural two-wire target: acks, logs the bytes it is sent, returns one byte on reads
`timescale 1ns/1ps

module sbm_target #(
   parameter logic [6:0] TGT_ADDR = 7'h50  // Bus address answered
)(
   input  wire logic        scl,      // Resolved clock wire
   input  wire logic        sda,      // Resolved data wire
   input  wire logic        nack_all, // Refuse every byte
   input  wire logic [7:0]  tx_byte,  // Byte returned on reads
   output logic             sda_oe,   // High while pulling data low
   output logic      [31:0] rx_log    // Bytes received, newest in the low byte
);
   logic [7:0] sh;       // Incoming bits
   int         bits;     // Clock pulses since start or last ack
   logic       first;    // Next byte is the address byte
   logic       rd_mode;  // Sending data after a read address
   initial begin
      sda_oe = 1'b0;
      rx_log = '0;
      bits = 0;
      first = 1'b1;
      rd_mode = 1'b0;
   end
   // Start or repeated start: data falls while the clock is high
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         bits = 0;
         first = 1'b1;
         rd_mode = 1'b0;
      end
   end
   // Sample on the rising clock, most significant bit first
   always @(posedge scl) begin
      if (bits < 8) sh = {sh[6:0], sda};
      bits = bits + 1;
   end
   // Change data only while the clock is low; released lines float to the pull-up
   always @(negedge scl) begin
      sda_oe <= 1'b0;
      if (bits == 8) begin
         if (first || !rd_mode) begin
            rx_log = {rx_log[23:0], sh};
            sda_oe <= !nack_all && (!first || sh[7:1] == TGT_ADDR);  // Ack unless told to refuse or the address byte names another target
         end
         rd_mode = first && sh[0];
      end else if (bits == 9) begin
         bits = 0;
         first = 1'b0;
         if (rd_mode) sda_oe <= !tx_byte[7];
      end else if (rd_mode && !first && bits < 8) begin
         sda_oe <= !tx_byte[7 - bits];
      end
   end
endmodule // sbm_target

// File: dv/test_sbm_master.sv
// Self-checking bench: register traffic against a behavioural bus target
`timescale 1ns/1ps

module test_sbm_master
   import sbm_pkg::*;
;
   localparam logic [6:0] TGT = 7'h5a;                         // Target address, any value works
   logic        clock, link_clock, reset_n, cfg_wr, cfg_rd;    // Clocks and strobes
   logic        nack_all, scl_o, scl_oe, sda_o, sda_oe, tgt_oe; // Fault switch and line drives
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, tx_byte, rd, d, idx; // Port values and scratch
   logic [31:0] rx_log;                                         // Bytes the target saw
   int          fails, compares, cyc;                           // Score and busy time
   wire         scl = !scl_oe;                                  // Pull-up unless pulled low
   wire         sda = !(sda_oe || tgt_oe);                      // Either party may pull low
   sbm_master i_dut (.clock(clock), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .link_clock(link_clock), .scl_i(scl), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   sbm_target #(.TGT_ADDR(TGT)) i_tgt (.scl(scl), .sda(sda), .nack_all(nack_all), .tx_byte(tx_byte),
      .sda_oe(tgt_oe), .rx_log(rx_log));
   // -------------------------------------------------------------
   // Clocks, unrelated in phase
   // -------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      link_clock = 1'b0;
      #3;
      forever #16 link_clock = ~link_clock;
   end
   task automatic print_verdict();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bytes the target should have logged for one access, newest in the low byte
   function automatic logic [31:0] exp_log(input logic shrt, input logic rd_dir,
                                           input logic [7:0] idx_b, input logic [7:0] dat_b);
      if (rd_dir) begin
         return shrt ? {24'h0, TGT, 1'b1} : {8'h0, TGT, 1'b0, idx_b, TGT, 1'b1};
      end
      return shrt ? {16'h0, TGT, 1'b0, dat_b} : {8'h0, TGT, 1'b0, idx_b, dat_b};
   endfunction
   // Strobes rise and fall on falling edges, so the rising edge sees them settled
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock);
      cfg_addr = a;
      cfg_wdata = v;
      cfg_wr = 1'b1;
      @(negedge clock);
      cfg_wr = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clock);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(negedge clock);
      cfg_rd = 1'b0;
      @(negedge clock);
      v = cfg_rdata;
   endtask
   task automatic zero_check();
      for (int a = 0; a < 5; a++) begin
         reg_rd(8'hb0 + 8'(a), rd);
         check("reset value", 32'h0, 32'(rd));
      end
      check("drive level", 32'h0, 32'({scl_o, sda_o, scl_oe, sda_oe}));
   endtask
   // Launch, poll busy under a bound, then judge status and duration in quarters of a bit
   task automatic run(input logic [7:0] ta, input int q, input int quarters, input logic [7:0] ctrl);
      int     n;
      time    t0;
      longint lim;
      reg_wr(OFS_TADDR, ta);
      reg_rd(OFS_CTRL, rd);
      check("busy", 32'h1, 32'(rd[CTRL_BUSY_BIT]));
      t0 = $time;
      n = 0;
      do begin
         reg_rd(OFS_CTRL, rd);
         n++;
      end while (rd[CTRL_BUSY_BIT] !== 1'b0 && n < 20000);
      if (n >= 20000) begin
         fails++;
         $display("ERROR busy expected 0 seen 1");
         print_verdict();
      end
      lim = quarters * q * 32 / 10;
      cyc = int'(($time - t0) / 10);
      check("ctrl", 32'(ctrl), 32'(rd));
      check("span", 32'h1, 32'(cyc * 10 > lim * 9 && cyc * 2 < lim * 3));
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {reset_n, cfg_wr, cfg_rd, nack_all} = '0;
      {cfg_addr, cfg_wdata, tx_byte} = '0;
      fails = 0;
      compares = 0;
      void'($urandom(32'h48d36dbd));
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      zero_check();
      // Odd passes use the short protocol; all run at the raised test rate to keep the run short
      for (int m = 0; m < 4; m++) begin
         reg_wr(OFS_CTRL, m[0] ? 8'h84 : 8'h04);
         d = 8'($urandom);
         idx = 8'($urandom);
         tx_byte = 8'($urandom);
         reg_wr(OFS_DATA, d);
         reg_wr(OFS_INDEX, idx);
         run({TGT, 1'b0}, Q_TEST_CYC, m[0] ? 80 : 116, m[0] ? 8'h84 : 8'h04);
         check("sent", exp_log(m[0], 1'b0, idx, d), rx_log & (m[0] ? 32'hffff : 32'hffffff));
         run({TGT, 1'b1}, Q_TEST_CYC, m[0] ? 80 : 156, m[0] ? 8'h84 : 8'h04);
         reg_rd(OFS_DATA, rd);
         check("read byte", 32'(tx_byte), 32'(rd));
         check("sent", exp_log(m[0], 1'b1, idx, d), rx_log & (m[0] ? 32'hff : 32'hffffff));
      end
      // A refused address ends the access at once and leaves the sticky flag up
      nack_all = 1'b1;
      reg_wr(OFS_CTRL, 8'h04);
      run({TGT, 1'b0}, Q_TEST_CYC, 44, 8'h06);
      nack_all = 1'b0;
      reg_wr(OFS_CTRL, 8'h06);
      reg_rd(OFS_CTRL, rd);
      check("ctrl", 32'h04, 32'(rd));
      // One access at the normal rate
      reg_wr(OFS_CTRL, 8'h00);
      run({TGT, 1'b0}, Q_NORM_CYC, 116, 8'h00);
      // The last read left its received byte in the data register, so that byte is sent
      check("sent", exp_log(1'b0, 1'b0, idx, tx_byte), rx_log & 32'hffffff);
      // Reset after the last access clears every register
      reset_n = 1'b0;
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      zero_check();
      print_verdict();
   end
endmodule // test_sbm_master
